/* File: src/rbxcv_pkg.sv */
// rbxcv_pkg: shared constants and carriers for the registered bus transceiver
package rbxcv_pkg;

   // ==========================================================
   // widths
   localparam int unsigned BUS_W  = 8;
   localparam int unsigned WB_AW  = 8;
   localparam int unsigned WB_DW  = 32;
   localparam int unsigned LOG_D  = 8;

   // ==========================================================
   // register byte offsets
   localparam logic [WB_AW-1:0] CTRL_OFS   = 8'h00;
   localparam logic [WB_AW-1:0] STORE_OFS  = 8'h04;
   localparam logic [WB_AW-1:0] LIVE_OFS   = 8'h08;
   localparam logic [WB_AW-1:0] STATUS_OFS = 8'h0c;
   localparam logic [WB_AW-1:0] LOG_OFS    = 8'h10;

   // ==========================================================
   // field positions
   localparam int unsigned CTRL_W      = 4;
   localparam int unsigned HI_LSB      = 8;
   localparam int unsigned LOG_HIT_LSB = 16;
   localparam int unsigned LOG_VLD_BIT = 31;
   localparam int unsigned ST_VLD_BIT  = 0;
   localparam int unsigned ST_OVF_BIT  = 1;
   localparam int unsigned ST_RDY_BIT  = 2;

   // ==========================================================
   // control word: isolation after reset
   typedef struct packed {
      logic a_side_source_select;
      logic b_side_source_select;
      logic b_to_a_drive_enable_n;
      logic a_to_b_drive_enable;
   } rbxcv_ctrl_t;

   localparam rbxcv_ctrl_t CTRL_RST = rbxcv_ctrl_t'(4'h2);

   // one capture-log entry
   typedef struct packed {
      logic             b_hit;
      logic             a_hit;
      logic [BUS_W-1:0] b_data;
      logic [BUS_W-1:0] a_data;
   } rbxcv_log_t;

   localparam int unsigned LOG_W = $bits(rbxcv_log_t);

   // pin samples crossing into clk_i
   typedef struct packed {
      logic             b_clk;
      logic             a_clk;
      logic [BUS_W-1:0] b_bus;
      logic [BUS_W-1:0] a_bus;
   } rbxcv_pins_t;

   localparam int unsigned PINS_W = $bits(rbxcv_pins_t);

endpackage

/* File: src/rbxcv_sync.sv */
// rbxcv_sync: two-flop synchroniser for a group of pin levels
`timescale 1ns/1ps
`default_nettype none
module rbxcv_sync #(
   parameter int unsigned W = 1
) (
   // clock and reset
   input  wire logic         clk_i,
   input  wire logic         rst_i,
   // levels
   input  wire logic [W-1:0] d_i,
   output var  logic [W-1:0] q_o
);

   logic [W-1:0] meta_ff;
   logic [W-1:0] nxt_meta;
   logic [W-1:0] nxt_q;

   // ==========================================================
   // next values
   always_comb begin
      nxt_meta = rst_i ? '0 : d_i;
      nxt_q    = rst_i ? '0 : meta_ff;
   end

   // first stage feeds only the second
   always_ff @(posedge clk_i) begin
      meta_ff <= nxt_meta;
      q_o     <= nxt_q;
   end

endmodule
`default_nettype wire

/* File: src/rbxcv_fifo.sv */
// rbxcv_fifo: flip-flop FIFO with valid/ready on both sides
`timescale 1ns/1ps
`default_nettype none
module rbxcv_fifo #(
   parameter int unsigned W = 8,
   parameter int unsigned D = 8
) (
   // clock and reset
   input  wire logic         clk_i,
   input  wire logic         rst_i,
   // fill side
   input  wire logic         in_valid_i,
   output var  logic         in_ready_o,
   input  wire logic [W-1:0] in_data_i,
   // drain side
   output var  logic         out_valid_o,
   input  wire logic         out_ready_i,
   output var  logic [W-1:0] out_data_o
);

   localparam int unsigned PW = $clog2(D);
   localparam int unsigned CW = $clog2(D + 1);
   localparam logic [CW-1:0] FULL_CNT = CW'(D);
   localparam logic [PW-1:0] LAST_IX  = PW'(D - 1);

   logic [W-1:0]  mem_ff [D];
   logic [PW-1:0] wr_ff;
   logic [PW-1:0] rd_ff;
   logic [CW-1:0] cnt_ff;
   logic [PW-1:0] nxt_wr;
   logic [PW-1:0] nxt_rd;
   logic [CW-1:0] nxt_cnt;
   logic          push;
   logic          pop;

   // ==========================================================
   // pointers and count
   always_comb begin
      push    = in_valid_i && in_ready_o;
      pop     = out_valid_o && out_ready_i;
      nxt_wr  = wr_ff;
      nxt_rd  = rd_ff;
      nxt_cnt = cnt_ff;
      if (push) begin
         nxt_wr = (wr_ff == LAST_IX) ? '0 : wr_ff + 1'b1;
      end
      if (pop) begin
         nxt_rd = (rd_ff == LAST_IX) ? '0 : rd_ff + 1'b1;
      end
      if (push && !pop) begin
         nxt_cnt = cnt_ff + 1'b1;
      end else if (pop && !push) begin
         nxt_cnt = cnt_ff - 1'b1;
      end
      if (rst_i) begin
         nxt_wr  = '0;
         nxt_rd  = '0;
         nxt_cnt = '0;
      end
   end

   always_ff @(posedge clk_i) begin
      wr_ff       <= nxt_wr;
      rd_ff       <= nxt_rd;
      cnt_ff      <= nxt_cnt;
      in_ready_o  <= (nxt_cnt != FULL_CNT);
      out_valid_o <= (nxt_cnt != '0);
      if (push) begin
         mem_ff[wr_ff] <= in_data_i;
      end
   end

   assign out_data_o = mem_ff[rd_ff];

endmodule
`default_nettype wire

/* File: src/rbxcv_top.sv */
// rbxcv_top: registered octal bus transceiver with a Wishbone control port
`timescale 1ns/1ps
`default_nettype none
module rbxcv_top
   import rbxcv_pkg::*;
#(
   parameter int unsigned LOG_DEPTH = rbxcv_pkg::LOG_D
) (
   // clock and reset
   input  wire logic                          clk_i,
   input  wire logic                          rst_i,
   // wishbone slave
   input  wire logic                          wb_cyc_i,
   input  wire logic                          wb_stb_i,
   input  wire logic                          wb_we_i,
   input  wire logic [rbxcv_pkg::WB_AW-1:0]   wb_adr_i,
   input  wire logic [3:0]                    wb_sel_i,
   input  wire logic [rbxcv_pkg::WB_DW-1:0]   wb_dat_i,
   output var  logic [rbxcv_pkg::WB_DW-1:0]   wb_dat_o,
   output var  logic                          wb_ack_o,
   // capture clock pins
   input  wire logic                          a_capture_clock_i,
   input  wire logic                          b_capture_clock_i,
   // a bus pins
   input  wire logic [rbxcv_pkg::BUS_W-1:0]   a_bus_i,
   output var  logic [rbxcv_pkg::BUS_W-1:0]   a_bus_o,
   output var  logic                          a_bus_oe_n_o,
   // b bus pins
   input  wire logic [rbxcv_pkg::BUS_W-1:0]   b_bus_i,
   output var  logic [rbxcv_pkg::BUS_W-1:0]   b_bus_o,
   output var  logic                          b_bus_oe_n_o,
   // capture log back-pressure
   output var  logic                          log_ready_o
);
   import rbxcv_pkg::*;

   // ==========================================================
   // pin synchronisation
   rbxcv_pins_t pins_raw;
   rbxcv_pins_t pins_s;
   logic        a_clk_prev_ff;
   logic        b_clk_prev_ff;
   logic        nxt_a_clk_prev;
   logic        nxt_b_clk_prev;
   logic        a_edge;
   logic        b_edge;

   always_comb begin
      pins_raw.b_clk = b_capture_clock_i;
      pins_raw.a_clk = a_capture_clock_i;
      pins_raw.b_bus = b_bus_i;
      pins_raw.a_bus = a_bus_i;
   end

   // data and clocks share one synchroniser so they stay aligned
   rbxcv_sync #(
      .W (PINS_W)
   ) u_sync (
      .clk_i (clk_i),
      .rst_i (rst_i),
      .d_i   (pins_raw),
      .q_o   (pins_s)
   );

   always_comb begin
      nxt_a_clk_prev = rst_i ? 1'b0 : pins_s.a_clk;
      nxt_b_clk_prev = rst_i ? 1'b0 : pins_s.b_clk;
   end

   always_ff @(posedge clk_i) begin
      a_clk_prev_ff <= nxt_a_clk_prev;
      b_clk_prev_ff <= nxt_b_clk_prev;
   end

   // rising edges of the capture clocks
   assign a_edge = pins_s.a_clk && !a_clk_prev_ff;
   assign b_edge = pins_s.b_clk && !b_clk_prev_ff;

   // ==========================================================
   // storage registers
   logic [BUS_W-1:0] a_store_ff;
   logic [BUS_W-1:0] b_store_ff;
   logic [BUS_W-1:0] nxt_a_store;
   logic [BUS_W-1:0] nxt_b_store;

   // capture ignores enables and selects; the sampled level is the
   // resolved wire, so a bus we drive loads our own output
   always_comb begin
      nxt_a_store = a_store_ff;
      nxt_b_store = b_store_ff;
      if (a_edge) begin
         nxt_a_store = pins_s.a_bus;
      end
      if (b_edge) begin
         nxt_b_store = pins_s.b_bus;
      end
   end

   // no reset: contents stay unknown until the first capture edge
   always_ff @(posedge clk_i) begin
      a_store_ff <= nxt_a_store;
      b_store_ff <= nxt_b_store;
   end

   // ==========================================================
   // control register and bus drivers
   rbxcv_ctrl_t      ctrl_ff;
   rbxcv_ctrl_t      nxt_ctrl;
   logic [BUS_W-1:0] nxt_a_bus;
   logic [BUS_W-1:0] nxt_b_bus;
   logic             nxt_a_oe_n;
   logic             nxt_b_oe_n;
   logic             wb_req;
   logic             wb_wr;
   logic             wb_rd;

   assign wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
   assign wb_wr  = wb_req && wb_we_i;
   assign wb_rd  = wb_req && !wb_we_i;

   // ==========================================================
   // register decode
   // writes act on byte lane 0 only; every writable field sits in
   // the low byte, so the upper lanes carry nothing
   logic             hit_ctrl;
   logic             hit_status;
   logic             hit_log;
   logic             wr_ctrl;
   logic             clr_ovf;
   logic             rd_log;

   always_comb begin
      hit_ctrl   = (wb_adr_i == CTRL_OFS);
      hit_status = (wb_adr_i == STATUS_OFS);
      hit_log    = (wb_adr_i == LOG_OFS);
      wr_ctrl    = wb_wr && hit_ctrl && wb_sel_i[0];
      clr_ovf    = wb_wr && hit_status && wb_sel_i[0] && wb_dat_i[ST_OVF_BIT];
      rd_log     = wb_rd && hit_log;
   end

   always_comb begin
      nxt_ctrl = ctrl_ff;
      if (wr_ctrl) begin
         nxt_ctrl = rbxcv_ctrl_t'(wb_dat_i[CTRL_W-1:0]);
      end
      if (rst_i) begin
         nxt_ctrl = CTRL_RST;
      end
   end

   // live paths pass the synchroniser, so a keeper loop settles on
   // the last driven level once the other sources release the wires
   always_comb begin
      nxt_b_bus = ctrl_ff.b_side_source_select
                ? a_store_ff
                : pins_s.a_bus;
      nxt_a_bus = ctrl_ff.a_side_source_select
                ? b_store_ff
                : pins_s.b_bus;
      nxt_b_oe_n = !ctrl_ff.a_to_b_drive_enable;
      nxt_a_oe_n = ctrl_ff.b_to_a_drive_enable_n;
      if (rst_i) begin
         nxt_a_bus  = '0;
         nxt_b_bus  = '0;
         nxt_a_oe_n = 1'b1;
         nxt_b_oe_n = 1'b1;
      end
   end

   always_ff @(posedge clk_i) begin
      ctrl_ff      <= nxt_ctrl;
      a_bus_o      <= nxt_a_bus;
      b_bus_o      <= nxt_b_bus;
      a_bus_oe_n_o <= nxt_a_oe_n;
      b_bus_oe_n_o <= nxt_b_oe_n;
   end

   // ==========================================================
   // capture log
   rbxcv_log_t log_in;
   rbxcv_log_t log_out;
   logic       log_push;
   logic       log_vld;
   logic       log_pop;
   logic       log_lost;
   logic       ovf_ff;
   logic       nxt_ovf;

   // one entry per cycle with any edge; a full log drops the entry
   // but never blocks the capture itself
   always_comb begin
      log_in.b_hit  = b_edge;
      log_in.a_hit  = a_edge;
      log_in.b_data = pins_s.b_bus;
      log_in.a_data = pins_s.a_bus;
      log_push      = a_edge || b_edge;
      log_pop       = rd_log;
      log_lost      = log_push && !log_ready_o;
   end

   rbxcv_fifo #(
      .W (LOG_W),
      .D (LOG_DEPTH)
   ) u_log (
      .clk_i       (clk_i),
      .rst_i       (rst_i),
      .in_valid_i  (log_push),
      .in_ready_o  (log_ready_o),
      .in_data_i   (log_in),
      .out_valid_o (log_vld),
      .out_ready_i (log_pop),
      .out_data_o  (log_out)
   );

   // overflow: a lost entry wins over a clear in the same cycle
   always_comb begin
      nxt_ovf = ovf_ff;
      if (clr_ovf) begin
         nxt_ovf = 1'b0;
      end
      if (log_lost) begin
         nxt_ovf = 1'b1;
      end
      if (rst_i) begin
         nxt_ovf = 1'b0;
      end
   end

   always_ff @(posedge clk_i) begin
      ovf_ff <= nxt_ovf;
   end

   // ==========================================================
   // wishbone read data and acknowledge
   logic [WB_DW-1:0] nxt_dat;
   logic             nxt_ack;

   always_comb begin
      nxt_dat = '0;
      unique case (wb_adr_i)
         CTRL_OFS: begin
            nxt_dat[CTRL_W-1:0] = ctrl_ff;
         end
         STORE_OFS: begin
            nxt_dat[BUS_W-1:0]               = a_store_ff;
            nxt_dat[HI_LSB +: BUS_W]         = b_store_ff;
         end
         LIVE_OFS: begin
            nxt_dat[BUS_W-1:0]               = pins_s.a_bus;
            nxt_dat[HI_LSB +: BUS_W]         = pins_s.b_bus;
         end
         STATUS_OFS: begin
            nxt_dat[ST_VLD_BIT]              = log_vld;
            nxt_dat[ST_OVF_BIT]              = ovf_ff;
            nxt_dat[ST_RDY_BIT]              = log_ready_o;
         end
         LOG_OFS: begin
            if (log_vld) begin
               nxt_dat[BUS_W-1:0]            = log_out.a_data;
               nxt_dat[HI_LSB +: BUS_W]      = log_out.b_data;
               nxt_dat[LOG_HIT_LSB]          = log_out.a_hit;
               nxt_dat[LOG_HIT_LSB + 1]      = log_out.b_hit;
               nxt_dat[LOG_VLD_BIT]          = 1'b1;
            end
         end
         default: begin
            nxt_dat = '0;
         end
      endcase
      if (!wb_rd || rst_i) begin
         nxt_dat = '0;
      end
   end

   // taken once: ack is low on the edge after it rose, but a master
   // that still holds stb is answered again every second cycle
   always_comb begin
      nxt_ack = wb_req && !rst_i;
   end

   always_ff @(posedge clk_i) begin
      wb_dat_o <= nxt_dat;
      wb_ack_o <= nxt_ack;
   end

   // each capture clock has its own edge detector, so the far end
   // may raise both in the same cycle and both stores load

endmodule
`default_nettype wire

/* File: tb/rbxcv_props.sv */
// rbxcv_props: concurrent checks on the transceiver top ports
`timescale 1ns/1ps
`default_nettype none
module rbxcv_props
   import rbxcv_pkg::*;
(
   // clock and reset
   input  wire logic                        clk_i,
   input  wire logic                        rst_i,
   // wishbone
   input  wire logic                        wb_cyc_i,
   input  wire logic                        wb_stb_i,
   input  wire logic                        wb_we_i,
   input  wire logic [rbxcv_pkg::WB_AW-1:0] wb_adr_i,
   input  wire logic [3:0]                  wb_sel_i,
   input  wire logic [rbxcv_pkg::WB_DW-1:0] wb_dat_i,
   input  wire logic                        wb_ack_o,
   // pins
   input  wire logic                        a_capture_clock_i,
   input  wire logic                        b_capture_clock_i,
   input  wire logic [rbxcv_pkg::BUS_W-1:0] a_bus_i,
   input  wire logic [rbxcv_pkg::BUS_W-1:0] b_bus_i,
   input  wire logic [rbxcv_pkg::BUS_W-1:0] a_bus_o,
   input  wire logic                        a_bus_oe_n_o,
   input  wire logic [rbxcv_pkg::BUS_W-1:0] b_bus_o,
   input  wire logic                        b_bus_oe_n_o
);
   // ==========================================================
   // shadow of the control word; calm once outputs had time to follow
   rbxcv_ctrl_t ctrl_ff;
   rbxcv_ctrl_t nxt_ctrl;
   logic [1:0]  calm_ff;
   logic [1:0]  nxt_calm;
   logic        wr_ctrl;
   logic        calm;
   assign wr_ctrl = wb_cyc_i & wb_stb_i & ~wb_ack_o & wb_we_i & wb_sel_i[0]
                    & (wb_adr_i == CTRL_OFS);
   assign calm = (calm_ff == 2'h3);
   always_comb begin
      nxt_ctrl = wr_ctrl ? rbxcv_ctrl_t'(wb_dat_i[CTRL_W-1:0]) : ctrl_ff;
      nxt_calm = wr_ctrl ? 2'h0 : (calm ? calm_ff : calm_ff + 2'h1);
      if (rst_i) begin
         nxt_ctrl = CTRL_RST;
         nxt_calm = 2'h0;
      end
   end
   always_ff @(posedge clk_i) begin
      ctrl_ff <= nxt_ctrl;
      calm_ff <= nxt_calm;
   end
   default clocking cb @(posedge clk_i); endclocking
   // ==========================================================
   // assertions
   reset_isol_a: assert property (rst_i |=> a_bus_oe_n_o && b_bus_oe_n_o)
      else $error("buses driven after reset");
   ack_pulse_a: assert property (disable iff (rst_i) wb_ack_o |=> !wb_ack_o)
      else $error("ack held for more than one cycle");
   b_drive_a: assert property (disable iff (rst_i)
      calm |-> b_bus_oe_n_o == !ctrl_ff.a_to_b_drive_enable) else $error("b enable wrong");
   a_drive_a: assert property (disable iff (rst_i)
      calm |-> a_bus_oe_n_o == ctrl_ff.b_to_a_drive_enable_n) else $error("a enable wrong");
   b_live_a: assert property (disable iff (rst_i)
      (calm && ctrl_ff.a_to_b_drive_enable && !ctrl_ff.b_side_source_select
      && $stable(a_bus_i))[*4] |-> b_bus_o == a_bus_i)
      else $error("b live data wrong");
   a_live_a: assert property (disable iff (rst_i)
      (calm && !ctrl_ff.b_to_a_drive_enable_n && !ctrl_ff.a_side_source_select
      && $stable(b_bus_i))[*4] |-> a_bus_o == b_bus_i)
      else $error("a live data wrong");
   keep_loop_a: assert property (disable iff (rst_i)
      (calm && ctrl_ff == rbxcv_ctrl_t'(4'h1)
      && $stable(a_bus_i) && $stable(b_bus_i))[*4] |-> a_bus_i == b_bus_i)
      else $error("keeper loop not settled");
   b_hold_a: assert property (disable iff (rst_i)
      (calm && ctrl_ff.b_side_source_select && ctrl_ff.a_to_b_drive_enable
      && !a_capture_clock_i)[*5] |-> $stable(b_bus_o))
      else $error("stored a moved on b");
   a_hold_a: assert property (disable iff (rst_i)
      (calm && ctrl_ff.a_side_source_select && !ctrl_ff.b_to_a_drive_enable_n
      && !b_capture_clock_i)[*5] |-> $stable(a_bus_o))
      else $error("stored b moved on a");
   c_ctrl: cover property (wr_ctrl);
   c_keep: cover property (calm && ctrl_ff == rbxcv_ctrl_t'(4'h1));
   c_both: cover property (calm && ctrl_ff == rbxcv_ctrl_t'(4'hd));
endmodule
bind rbxcv_top rbxcv_props chk_i (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
   .wb_sel_i, .wb_dat_i, .wb_ack_o, .a_capture_clock_i, .b_capture_clock_i, .a_bus_i,
   .b_bus_i, .a_bus_o, .a_bus_oe_n_o, .b_bus_o, .b_bus_oe_n_o);
`default_nettype wire

/* File: tb/rbxcv_far.sv */
// rbxcv_far: far-side party sharing one transceiver bus
`timescale 1ns/1ps
`default_nettype none
module rbxcv_far
   import rbxcv_pkg::*;
(
   // clock
   input  wire logic                        clk_i,
   // far party drive
   input  wire logic                        far_en_i,
   input  wire logic [rbxcv_pkg::BUS_W-1:0] far_val_i,
   // device pins
   input  wire logic [rbxcv_pkg::BUS_W-1:0] dev_val_i,
   input  wire logic                        dev_oe_n_i,
   // resolved line
   output var  logic [rbxcv_pkg::BUS_W-1:0] wire_o
);
   // ==========================================================
   // no pull on the line: a floating bus shows the inverse of its last driven level
   logic [BUS_W-1:0] last_ff = 8'h00;
   always_comb begin
      if (!dev_oe_n_i) begin
         wire_o = dev_val_i;
      end else if (far_en_i) begin
         wire_o = far_val_i;
      end else begin
         wire_o = ~last_ff;
      end
   end
   always_ff @(posedge clk_i) begin
      if (!dev_oe_n_i || far_en_i) begin
         last_ff <= wire_o;
      end
   end
endmodule
`default_nettype wire

/* File: tb/rbxcv_top_tb.sv */
// rbxcv_top_tb: register-level tests of the transceiver
`timescale 1ns/1ps
`default_nettype none
module rbxcv_top_tb;
   import rbxcv_pkg::*;
   // ==========================================================
   // signals
   logic        clk_i = 1'b0;
   logic        rst_i = 1'b1;
   logic        cyc = 1'b0;
   logic        stb = 1'b0;
   logic        we = 1'b0;
   logic [7:0]  adr = 8'h00;
   logic [3:0]  sel = 4'hf;
   logic [31:0] dat = 32'h0;
   logic [31:0] dat_o;
   logic [31:0] rdat;
   logic        ack_o, cap_a = 1'b0, cap_b = 1'b0, a_en = 1'b1, b_en = 1'b1;
   logic        a_oe_n, b_oe_n, log_rdy;
   logic [7:0]  a_val = 8'h00, b_val = 8'h00, a_out, b_out, a_wire, b_wire;
   int          fails = 0;
   int          n_compared = 0;
   always #2.5 clk_i = ~clk_i;
   rbxcv_top uut (.clk_i, .rst_i, .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
      .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(dat_o), .wb_ack_o(ack_o),
      .a_capture_clock_i(cap_a), .b_capture_clock_i(cap_b), .a_bus_i(a_wire),
      .a_bus_o(a_out), .a_bus_oe_n_o(a_oe_n), .b_bus_i(b_wire), .b_bus_o(b_out),
      .b_bus_oe_n_o(b_oe_n), .log_ready_o(log_rdy));
   rbxcv_far far_a (.clk_i, .far_en_i(a_en), .far_val_i(a_val), .dev_val_i(a_out),
      .dev_oe_n_i(a_oe_n), .wire_o(a_wire));
   rbxcv_far far_b (.clk_i, .far_en_i(b_en), .far_val_i(b_val), .dev_val_i(b_out),
      .dev_oe_n_i(b_oe_n), .wire_o(b_wire));
   // ==========================================================
   // tasks
   task test_done;
      $display("compared %0d failed %0d", n_compared, fails);
      if (fails == 0 && n_compared > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   task chk(input logic [31:0] got, input logic [31:0] exp, input string m);
      n_compared++;
      if (got !== exp) begin
         fails++;
         $display("CHECK FAILED %0t %s got %h exp %h", $time, m, got, exp);
      end
   endtask
   // classic cycle; waits for ack under a bound, takes read data at that edge
   task automatic wb(input logic w, input logic [7:0] ad, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk_i);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= ad;
      dat <= d;
      do begin
         @(posedge clk_i);
         n++;
      end while (ack_o !== 1'b1 && n < 16);
      rdat = dat_o;
      chk({31'h0, ack_o}, 32'h1, "no ack");
      cyc <= 1'b0;
      stb <= 1'b0;
   endtask
   task rc(input logic [7:0] ad, input logic [31:0] exp, input logic [31:0] m, input string s);
      wb(1'b0, ad, 32'h0);
      chk(rdat & m, exp, s);
   endtask
   // capture clock levels held 3 cycles, then settle time for the store
   task pulse(input logic pa, input logic pb);
      @(posedge clk_i);
      cap_a <= pa;
      cap_b <= pb;
      repeat (3) @(posedge clk_i);
      cap_a <= 1'b0;
      cap_b <= 1'b0;
      repeat (5) @(posedge clk_i);
   endtask
   // ==========================================================
   // tests
   initial begin
      repeat (2) @(posedge clk_i);
      rst_i <= 1'b0;
      rc(CTRL_OFS, 32'h2, 32'hf, "ctrl reset");
      rc(8'h40, 32'h0, 32'hffffffff, "unmapped");
      for (int i = 0; i < 9; i++) begin
         a_val <= i[7:0];
         pulse(1'b1, 1'b0);
      end
      rc(STATUS_OFS, 32'h3, 32'h7, "log full");
      chk({31'h0, log_rdy}, 32'h0, "log ready pin low");
      for (int i = 0; i < 8; i++) rc(LOG_OFS, 32'h80010000 | i, 32'h8003ffff, "log entry");
      rc(LOG_OFS, 32'h0, 32'hffffffff, "log empty");
      wb(1'b1, STATUS_OFS, 32'h2);
      rc(STATUS_OFS, 32'h4, 32'h7, "overflow clear");
      chk({31'h0, log_rdy}, 32'h1, "log ready pin high");
      a_val <= 8'h5a;
      b_val <= 8'hc3;
      pulse(1'b1, 1'b1);
      rc(STORE_OFS, 32'hc35a, 32'hffff, "store both");
      chk({30'h0, a_oe_n, b_oe_n}, 32'h3, "isolation");
      a_val <= 8'h11;
      b_val <= 8'h22;
      pulse(1'b1, 1'b0);
      rc(STORE_OFS, 32'hc311, 32'hffff, "store a only");
      pulse(1'b0, 1'b1);
      rc(STORE_OFS, 32'h2211, 32'hffff, "store b only");
      rc(LIVE_OFS, 32'h2211, 32'hffff, "live pins");
      b_en <= 1'b0;
      wb(1'b1, CTRL_OFS, 32'h7);
      a_val <= 8'h33;
      repeat (6) @(posedge clk_i);
      chk({24'h0, b_wire}, 32'h11, "stored a on b");
      chk({30'h0, a_oe_n, b_oe_n}, 32'h2, "b driven a input");
      wb(1'b1, CTRL_OFS, 32'h3);
      repeat (6) @(posedge clk_i);
      chk({24'h0, b_wire}, 32'h33, "live a on b");
      pulse(1'b1, 1'b1);
      rc(STORE_OFS, 32'h3333, 32'hffff, "capture while driving");
      wb(1'b1, CTRL_OFS, 32'h8);
      a_en <= 1'b0;
      b_en <= 1'b1;
      b_val <= 8'h77;
      repeat (6) @(posedge clk_i);
      chk({30'h0, a_oe_n, b_oe_n}, 32'h1, "a driven b input");
      chk({24'h0, a_wire}, 32'h33, "stored b on a");
      a_val <= 8'h12;
      b_val <= 8'h34;
      wb(1'b1, CTRL_OFS, 32'h2);
      a_en <= 1'b1;
      pulse(1'b1, 1'b0);
      pulse(1'b0, 1'b1);
      wb(1'b1, CTRL_OFS, 32'hd);
      a_en <= 1'b0;
      b_en <= 1'b0;
      repeat (6) @(posedge clk_i);
      chk({16'h0, a_wire, b_wire}, 32'h3412, "both stored");
      a_val <= 8'h6c;
      wb(1'b1, CTRL_OFS, 32'h3);
      a_en <= 1'b1;
      repeat (6) @(posedge clk_i);
      wb(1'b1, CTRL_OFS, 32'h1);
      repeat (6) @(posedge clk_i);
      a_en <= 1'b0;
      repeat (10) @(posedge clk_i);
      chk({16'h0, a_wire, b_wire}, 32'h6c6c, "keeper");
      test_done;
   end
   initial begin
      repeat (20000) @(posedge clk_i);
      fails++;
      test_done;
   end
endmodule
`default_nettype wire
